// ### shared/lpc_pkg.sv
// Constants and types shared by the low-power and addressing control core.
// Assumes a 100 MHz system clock and a 14-bit program counter.
package lpc_pkg;
  localparam int PC_W = 14;
  localparam int RAM_AW = 10;
  localparam int ROM_W = 10;
  localparam logic [9:0] MEMREG_BASE = 10'h020;
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam int ROMDATA_AB_BIT = 8;
  localparam int ROMDATA_PORT_BIT = 9;
  localparam int MEMREG_DEPTH = 16;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_STANDBY,
    OP_STOP,
    OP_FAR_JUMP,
    OP_FAR_COND_JUMP,
    OP_FAR_CALL,
    OP_PAGE_JUMP,
    OP_ZERO_CALL,
    OP_TABLE_JUMP,
    OP_PATTERN,
    OP_MEMREG_LOAD,
    OP_MEMREG_SWAP,
    OP_RAM_INDIRECT,
    OP_RAM_DIRECT
  } op_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STANDBY,
    ST_STOP
  } pwr_state_t;
endpackage

// ### core/memreg_file.sv
// Sixteen-digit memory-register area, 4 bits per digit.
// Assumes single-cycle write and registered read on sys_clk.
`timescale 1ns/10ps
module memreg_file (
  input wire logic sys_clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic wr_en, // Write strobe.
  input wire logic [3:0] addr, // Digit index.
  input wire logic [3:0] wr_data, // Digit to write.
  output logic [3:0] rd_data_ff // Registered read digit.
);
  logic [3:0] mem_ff [lpc_pkg::MEMREG_DEPTH];
  logic [3:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = mem_ff[addr];
  end

  // Contents are not cleared by reset so they survive a stop recovery.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_ff[addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= lpc_pkg::NIB_RESET;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end
endmodule // memreg_file

// ### core/pc_target.sv
// Program-counter target calculation for all branch forms.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module pc_target (
  input wire lpc_pkg::op_t op, // Decoded operation.
  input wire logic [13:0] pc_inc, // Incremented program counter.
  input wire logic [13:0] imm, // Immediate field.
  input wire logic [3:0] acc, // Accumulator.
  input wire logic [3:0] breg, // B register.
  input wire logic status, // Branch condition flag.
  output logic [13:0] target // Next program counter.
);
  always_comb begin
    target = pc_inc;
    case (op)
      lpc_pkg::OP_FAR_JUMP: target = imm;
      lpc_pkg::OP_FAR_COND_JUMP,
      lpc_pkg::OP_FAR_CALL: begin
        if (status) begin
          target = imm;
        end
      end
      lpc_pkg::OP_PAGE_JUMP: begin
        if (status) begin
          // Page comes from the incremented PC, so a jump at offset 255
          // lands in the next page.
          target = {pc_inc[13:8], imm[7:0]};
        end
      end
      lpc_pkg::OP_ZERO_CALL: begin
        if (status) begin
          target = {8'h00, imm[5:0]};
        end
      end
      lpc_pkg::OP_TABLE_JUMP: target = {2'h0, imm[3:0], breg, acc};
      default: target = pc_inc;
    endcase
  end
endmodule // pc_target

// ### core/lpc_core.sv
// Low-power mode control, RAM address formation and branch control of a
// small 4-bit core. Assumes instructions arrive already decoded, one per
// cycle when instr_valid is high, and that irq_req is synchronous.
`timescale 1ns/10ps
//Contract
// - standby halts instruction clock and fetch
// - standby keeps oscillator, interrupts, timer running
// - standby holds registers, RAM and pins
// - reset during standby fully resets core; core resets state, PC and ports, while A, B and RAM address keep their values
// - interrupt wakes standby, resumes after instruction
// - wake services if enabled else pends
// - stop halts oscillator, interrupts and timer
// - stop recovery keeps RAM, registers undefined
// - indirect address is W, X, Y concatenated
// - direct address is full second word
// - memory registers are sixteen digits at 020
// - far jumps load all fourteen PC bits
// - page jump replaces low eight PC bits
// - page jump at offset 255 enters next page
// - zero-page call loads six bits, clears upper
// - table jump uses immediate, A and B
// - pattern bit 8 writes A and B
// - pattern bit 9 writes R1, R2 ports
// - pattern leaves PC sequential
// - stop asserts halt and floats pins
module lpc_core (
  input wire logic sys_clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic reset_pin, // Reset pin from outside, active high.
  input wire logic instr_valid, // Decoded instruction present.
  input wire lpc_pkg::op_t op, // Decoded operation.
  input wire logic [13:0] imm, // Immediate or second word.
  input wire logic status, // Branch condition flag.
  input wire logic irq_req, // Interrupt request level.
  input wire logic int_enable, // Interrupt enable flag.
  input wire logic [1:0] rw_reg, // W register.
  input wire logic [3:0] rx_reg, // X register.
  input wire logic [3:0] ry_reg, // Y register.
  input wire logic [9:0] rom_data, // Table-addressed ROM word.
  input wire logic [3:0] memreg_wdata, // Digit for memory-register write.
  output logic [13:0] pc_ff, // Program counter.
  output logic [3:0] acc_ff, // Accumulator.
  output logic [3:0] breg_ff, // B register.
  output logic [3:0] port_r1_ff, // R1 port output register.
  output logic [3:0] port_r2_ff, // R2 port output register.
  output logic [9:0] ram_addr_ff, // RAM address.
  output logic [3:0] memreg_rdata_ff, // Memory-register read digit.
  output logic fetch_en, // Instruction fetch enable.
  output logic exec_clk_en, // Instruction-execution clock gate.
  output logic osc_run, // Oscillator enable.
  output logic periph_run, // Timer and interrupt logic enable.
  output logic irq_take, // Take the interrupt this cycle.
  output logic irq_pending, // Request held while interrupts are off.
  output logic halt_signal, // Stop-mode halt indication.
  output logic pin_oe // I/O pin output enable.
);
  logic rst_meta_ff;
  logic rst_sync_ff;
  lpc_pkg::pwr_state_t state_ff;
  lpc_pkg::pwr_state_t nxt_state;
  logic [13:0] nxt_pc;
  logic [13:0] pc_next_target;
  logic [3:0] nxt_acc;
  logic [3:0] nxt_breg;
  logic [3:0] nxt_r1;
  logic [3:0] nxt_r2;
  logic [9:0] nxt_ram_addr;
  logic pend_ff;
  logic nxt_pend;
  logic take_ff;
  logic nxt_take;
  logic run_ok;
  logic memreg_we;

  // Reset pin crosses in through two flops.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= reset_pin;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign run_ok = (state_ff == lpc_pkg::ST_RUN) && instr_valid;

  always_comb begin
    nxt_state = state_ff;
    nxt_pend = pend_ff;
    nxt_take = 1'b0;
    case (state_ff)
      lpc_pkg::ST_RUN: begin
        if (instr_valid && op == lpc_pkg::OP_STANDBY) begin
          nxt_state = lpc_pkg::ST_STANDBY;
        end else if (instr_valid && op == lpc_pkg::OP_STOP) begin
          nxt_state = lpc_pkg::ST_STOP;
        end
        if (pend_ff && int_enable) begin
          nxt_take = 1'b1;
          nxt_pend = 1'b0;
        end
      end
      lpc_pkg::ST_STANDBY: begin
        if (irq_req) begin
          nxt_state = lpc_pkg::ST_RUN;
          nxt_take = int_enable;
          nxt_pend = !int_enable;
        end
      end
      lpc_pkg::ST_STOP: begin
        nxt_state = lpc_pkg::ST_STOP;
      end
      default: nxt_state = lpc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= lpc_pkg::ST_RUN;
      pend_ff <= 1'b0;
      take_ff <= 1'b0;
    end else if (rst_sync_ff) begin
      state_ff <= lpc_pkg::ST_RUN;
      pend_ff <= 1'b0;
      take_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      take_ff <= nxt_take;
    end
  end

  pc_target u_pc_target (
    .op(op),
    .pc_inc(14'(pc_ff + 14'h0001)),
    .imm(imm),
    .acc(acc_ff),
    .breg(breg_ff),
    .status(status),
    .target(pc_next_target)
  );

  always_comb begin
    nxt_pc = pc_ff;
    nxt_acc = acc_ff;
    nxt_breg = breg_ff;
    nxt_r1 = port_r1_ff;
    nxt_r2 = port_r2_ff;
    nxt_ram_addr = ram_addr_ff;
    if (run_ok) begin
      // Standby advances PC so wake resumes at the next instruction.
      nxt_pc = pc_next_target;
      case (op)
        lpc_pkg::OP_RAM_INDIRECT: begin
          nxt_ram_addr = {rw_reg, rx_reg, ry_reg};
        end
        lpc_pkg::OP_RAM_DIRECT: begin
          nxt_ram_addr = imm[9:0];
        end
        lpc_pkg::OP_MEMREG_LOAD,
        lpc_pkg::OP_MEMREG_SWAP: begin
          nxt_ram_addr = lpc_pkg::MEMREG_BASE | {6'h00, imm[3:0]};
        end
        lpc_pkg::OP_PATTERN: begin
          if (rom_data[lpc_pkg::ROMDATA_AB_BIT]) begin
            nxt_breg = rom_data[7:4];
            nxt_acc = rom_data[3:0];
          end
          if (rom_data[lpc_pkg::ROMDATA_PORT_BIT]) begin
            nxt_r2 = rom_data[7:4];
            nxt_r1 = rom_data[3:0];
          end
        end
        default: nxt_ram_addr = ram_addr_ff;
      endcase
    end
  end

  // A, B and RAM address hold through stop and the pin reset that ends it; software must reload them afterwards.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff <= lpc_pkg::PC_RESET;
      acc_ff <= lpc_pkg::NIB_RESET;
      breg_ff <= lpc_pkg::NIB_RESET;
      port_r1_ff <= lpc_pkg::PORT_RESET;
      port_r2_ff <= lpc_pkg::PORT_RESET;
      ram_addr_ff <= 10'h000;
    end else if (rst_sync_ff) begin
      pc_ff <= lpc_pkg::PC_RESET;
      port_r1_ff <= lpc_pkg::PORT_RESET;
      port_r2_ff <= lpc_pkg::PORT_RESET;
    end else begin
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      breg_ff <= nxt_breg;
      port_r1_ff <= nxt_r1;
      port_r2_ff <= nxt_r2;
      ram_addr_ff <= nxt_ram_addr;
    end
  end

  assign memreg_we = run_ok && (op == lpc_pkg::OP_MEMREG_SWAP);

  // Memory-register digits are not cleared by reset.
  memreg_file u_memreg (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(memreg_we),
    .addr(imm[3:0]),
    .wr_data(memreg_wdata),
    .rd_data_ff(memreg_rdata_ff)
  );

  assign fetch_en = (state_ff == lpc_pkg::ST_RUN);
  assign exec_clk_en = (state_ff == lpc_pkg::ST_RUN);
  assign osc_run = (state_ff != lpc_pkg::ST_STOP);
  assign periph_run = (state_ff != lpc_pkg::ST_STOP);
  assign irq_take = take_ff;
  assign irq_pending = pend_ff;
  assign halt_signal = (state_ff == lpc_pkg::ST_STOP);
  assign pin_oe = (state_ff != lpc_pkg::ST_STOP);
endmodule // lpc_core

// ### dv/lpc_core_monitor.sv
// Port-level checks for the low-power and addressing core.
// Assumes it is bound to lpc_core and watches only its ports.
`timescale 1ns/10ps
module lpc_core_monitor (
  input wire logic sys_clk, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic instr_valid, // Valid.
  input wire lpc_pkg::op_t op, // Op.
  input wire logic [13:0] imm, // Immediate.
  input wire logic [9:0] rom_data, // ROM word.
  input wire logic [13:0] pc_ff, // PC.
  input wire logic [3:0] acc_ff, // A.
  input wire logic [3:0] breg_ff, // B.
  input wire logic [9:0] ram_addr_ff, // RAM address.
  input wire logic fetch_en, // Fetch.
  input wire logic exec_clk_en, // Exec clock.
  input wire logic osc_run, // Oscillator.
  input wire logic periph_run, // Timer.
  input wire logic halt_signal, // Halt.
  input wire logic pin_oe // Pins.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic go;
  assign go = instr_valid && fetch_en;
  a_far_jump_load: assert property (go && op == lpc_pkg::OP_FAR_JUMP
    |=> pc_ff == $past(imm)) else $error("far jump target wrong");
  a_table_jump_tgt: assert property (go && op == lpc_pkg::OP_TABLE_JUMP
    |=> pc_ff == {2'h0, $past(imm[3:0]), $past(breg_ff), $past(acc_ff)})
    else $error("table jump target wrong");
  a_pattern_pc_seq: assert property (go && op == lpc_pkg::OP_PATTERN
    |=> pc_ff == $past(pc_ff) + 14'h1) else $error("pattern moved pc");
  a_pattern_ab_load: assert property (go && op == lpc_pkg::OP_PATTERN
    && rom_data[8] |=> {breg_ff, acc_ff} == $past(rom_data[7:0]))
    else $error("pattern a b wrong");
  a_direct_ram_addr: assert property (go && op == lpc_pkg::OP_RAM_DIRECT
    |=> ram_addr_ff == $past(imm[9:0])) else $error("direct address wrong");
  a_memreg_ram_addr: assert property (go && op == lpc_pkg::OP_MEMREG_LOAD
    |=> ram_addr_ff == {6'h02, $past(imm[3:0])}) else $error("memreg address");
  a_standby_entry: assert property (go && op == lpc_pkg::OP_STANDBY
    |=> !fetch_en && !exec_clk_en && osc_run && periph_run)
    else $error("standby entry wrong");
  a_standby_hold: assert property (!fetch_en && !halt_signal &&
    !$past(fetch_en) |-> $stable(pc_ff) && $stable(acc_ff) && $stable(breg_ff))
    else $error("standby state changed");
  a_stop_quiet: assert property (go && op == lpc_pkg::OP_STOP |=>
    (halt_signal && !pin_oe && !osc_run && !periph_run)[*3])
    else $error("stop mode not quiet");
endmodule // lpc_core_monitor
bind lpc_core lpc_core_monitor i_lpc_core_monitor (.*);

// ### dv/tb_top.sv
// Directed bench for the low-power and addressing core.
// Assumes lpc_core and lpc_pkg are compiled first.
`timescale 1ns/10ps
module tb_top;
  logic sys_clk, arst_n, reset_pin, instr_valid, status, irq_req, int_enable;
  lpc_pkg::op_t op;
  logic [13:0] imm, pc_ff;
  logic [1:0] rw_reg;
  logic [3:0] rx_reg, ry_reg, memreg_wdata, acc_ff, breg_ff, memreg_rdata_ff;
  logic [3:0] port_r1_ff, port_r2_ff;
  logic [9:0] rom_data, ram_addr_ff;
  logic fetch_en, exec_clk_en, osc_run, periph_run, irq_take, irq_pending;
  logic halt_signal, pin_oe;
  int errors, compares;
  lpc_core i_lpc_core (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [13:0] e, logic [13:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic issue(lpc_pkg::op_t o, logic [13:0] i);
    op <= o;
    imm <= i;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic pin_reset(int n);
    reset_pin <= 1'b1;
    cyc(n);
    reset_pin <= 1'b0;
    cyc(4);
  endtask
  task automatic t_branch();
    issue(lpc_pkg::OP_FAR_JUMP, 14'h2abc);
    chk("far jump", 14'h2abc, pc_ff);
    issue(lpc_pkg::OP_FAR_COND_JUMP, 14'h12ff);
    chk("far cond", 14'h12ff, pc_ff);
    issue(lpc_pkg::OP_PAGE_JUMP, 14'h0055);
    chk("page edge", 14'h1355, pc_ff);
    issue(lpc_pkg::OP_PAGE_JUMP, 14'h000a);
    chk("page jump", 14'h130a, pc_ff);
    issue(lpc_pkg::OP_FAR_CALL, 14'h0f0f);
    chk("far call", 14'h0f0f, pc_ff);
    issue(lpc_pkg::OP_ZERO_CALL, 14'h3fff);
    chk("zero call", 14'h003f, pc_ff);
    rom_data <= 10'h1a5;
    issue(lpc_pkg::OP_PATTERN, 14'h0000);
    chk("pattern pc", 14'h0040, pc_ff);
    issue(lpc_pkg::OP_TABLE_JUMP, 14'h0007);
    chk("table jump", 14'h07a5, pc_ff);
    status <= 1'b0;
    issue(lpc_pkg::OP_PAGE_JUMP, 14'h0011);
    chk("page untaken", 14'h07a6, pc_ff);
    issue(lpc_pkg::OP_ZERO_CALL, 14'h0001);
    chk("zero untaken", 14'h07a7, pc_ff);
    issue(lpc_pkg::OP_FAR_JUMP, 14'h0200);
    chk("far uncond", 14'h0200, pc_ff);
    status <= 1'b1;
    $display("test branch done");
  endtask
  task automatic t_pattern();
    logic [7:0] d, eab, ep;
    eab = 8'ha5;
    ep = 8'h00;
    for (int k = 0; k < 4; k++) begin
      d = 8'h3c + 8'(k);
      rom_data <= {k[1:0], d};
      issue(lpc_pkg::OP_PATTERN, 14'h0000);
      if (k[0]) eab = d;
      if (k[1]) ep = d;
      chk("acc b", eab, {breg_ff, acc_ff});
      chk("ports", ep, {port_r2_ff, port_r1_ff});
    end
    $display("test pattern done");
  endtask
  task automatic t_ram();
    issue(lpc_pkg::OP_RAM_INDIRECT, 14'h0000);
    chk("indirect", 10'h296, ram_addr_ff);
    issue(lpc_pkg::OP_RAM_DIRECT, 14'h21c3);
    chk("direct", 10'h1c3, ram_addr_ff);
    memreg_wdata <= 4'hb;
    issue(lpc_pkg::OP_MEMREG_SWAP, 14'h000f);
    memreg_wdata <= 4'h4;
    issue(lpc_pkg::OP_MEMREG_SWAP, 14'h0000);
    issue(lpc_pkg::OP_MEMREG_LOAD, 14'h000f);
    chk("memreg addr", 10'h02f, ram_addr_ff);
    cyc(1);
    chk("memreg digit", 4'hb, memreg_rdata_ff);
    $display("test ram done");
  endtask
  task automatic t_standby(logic ie);
    int n;
    issue(lpc_pkg::OP_FAR_JUMP, 14'h0100);
    int_enable <= ie;
    issue(lpc_pkg::OP_STANDBY, 14'h0000);
    chk("fetch exec", 2'b00, {fetch_en, exec_clk_en});
    chk("osc timer", 2'b11, {osc_run, periph_run});
    issue(lpc_pkg::OP_FAR_JUMP, 14'h3333);
    cyc(2);
    chk("held pc", 14'h0101, pc_ff);
    irq_req <= 1'b1;
    n = 0;
    while (fetch_en !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 20) begin
        errors++;
        give_verdict();
      end
    end
    chk("resume pc", 14'h0101, pc_ff);
    chk("take pend", {ie, !ie}, {irq_take, irq_pending});
    irq_req <= 1'b0;
    int_enable <= 1'b1;
    cyc(1);
    chk("late take", !ie, irq_take);
    $display("test standby done");
  endtask
  task automatic t_stop();
    issue(lpc_pkg::OP_STANDBY, 14'h0000);
    pin_reset(4);
    chk("standby fetch", 14'h0001, {13'h0000, fetch_en});
    chk("standby pc", 14'h0000, pc_ff);
    issue(lpc_pkg::OP_STOP, 14'h0000);
    cyc(3);
    chk("stop", 4'h8, {halt_signal, pin_oe, osc_run, periph_run});
    pin_reset(20);
    chk("stop exit", 4'h7, {halt_signal, pin_oe, osc_run, periph_run});
    issue(lpc_pkg::OP_MEMREG_LOAD, 14'h0000);
    cyc(1);
    chk("ram kept", 4'h4, memreg_rdata_ff);
    $display("test stop done");
  endtask
  initial begin
    arst_n = 1'b0;
    reset_pin = 1'b0;
    instr_valid = 1'b0;
    op = lpc_pkg::OP_NOP;
    imm = 14'h0000;
    status = 1'b1;
    irq_req = 1'b0;
    int_enable = 1'b0;
    rw_reg = 2'h2;
    rx_reg = 4'h9;
    ry_reg = 4'h6;
    rom_data = 10'h000;
    memreg_wdata = 4'h0;
    errors = 0;
    compares = 0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_branch();
    t_pattern();
    t_ram();
    t_standby(1'b1);
    t_standby(1'b0);
    t_stop();
    give_verdict();
  end
endmodule // tb_top
